// [hw/csw_defs.vh]
// constants for the chip select and wait-state controller
`ifndef CSW_DEFS_VH
`define CSW_DEFS_VH

// register indices and APB byte addresses (byte address = 4 * index)
`define CSW_IDX_BLK0        8'h68
`define CSW_IDX_BLK1        8'h69
`define CSW_IDX_BLK2        8'h6A
`define CSW_IDX_STAT        8'h6B
`define CSW_ADDR_BLK0       12'h1A0
`define CSW_ADDR_BLK1       12'h1A4
`define CSW_ADDR_BLK2       12'h1A8
`define CSW_ADDR_STAT       12'h1AC

// reset values of the block registers
`define CSW_RST_BLK0        8'h00
`define CSW_RST_BLK1        8'h00
`define CSW_RST_BLK2        8'h80

// field positions inside a block register
`define CSW_BIT_ENABLE      7
`define CSW_BIT_SYSONLY     6
`define CSW_BIT_WAVE        5
`define CSW_BIT_WIDTH       4
`define CSW_WAIT_HI         3
`define CSW_WAIT_LO         2
`define CSW_AREA_HI         1
`define CSW_AREA_LO         0

// wait field encodings
`define CSW_WAIT_TWO        2'b00
`define CSW_WAIT_ONE        2'b01
`define CSW_WAIT_PIN        2'b10
`define CSW_WAIT_NONE       2'b11

// wait states inserted per encoding
`define CSW_WS_TWO          2'h2
`define CSW_WS_ONE          2'h1
`define CSW_WS_NONE         2'h0

// fixed address areas selected by the area field
`define CSW_AREA_FIXED      2'b00
`define CSW_AREA_4M         2'b01
`define CSW_AREA_8M         2'b10
`define CSW_AREA_12M        2'b11

// default area bounds of each block
`define CSW_B0_LO           24'h007F00
`define CSW_B0_HI           24'h007FFF
`define CSW_B1_LO           24'h000480
`define CSW_B1_LO_NORAM     24'h000080
`define CSW_B1_HI           24'h007FFF
`define CSW_B2_LO           24'h008000
`define CSW_B2_LO_ROM       24'h010000
`define CSW_B2_HI           24'h3FFFFF

// operand size codes, log2 of the byte count
`define CSW_OP_BYTE         2'b00
`define CSW_OP_HALF         2'b01
`define CSW_OP_WORD         2'b10

`endif

// [hw/area_match.v]
// address area match for one chip select block
`timescale 1ns/100ps
`include "csw_defs.vh"

module area_match
#(
  parameter [23:0] FIXED_LO = 24'h000000,
  parameter [23:0] FIXED_HI = 24'h000000
)
(
  input  wire [7:0]  cfg,
  input  wire [23:0] addr,
  input  wire        system_mode,
  output wire        hit
);

  reg in_area;

  // area field picks the fixed window or one 4 Mbyte quarter
  always @*
  begin
    case (cfg[`CSW_AREA_HI:`CSW_AREA_LO])
      `CSW_AREA_FIXED: in_area = (addr >= FIXED_LO) && (addr <= FIXED_HI);
      `CSW_AREA_4M:    in_area = (addr[23:22] == 2'b01);
      `CSW_AREA_8M:    in_area = (addr[23:22] == 2'b10);
      `CSW_AREA_12M:   in_area = (addr[23:22] == 2'b11);
      default:         in_area = 1'b0;
    endcase
  end

  // master enable and system-mode qualification
  assign hit = cfg[`CSW_BIT_ENABLE] &
               (~cfg[`CSW_BIT_SYSONLY] | system_mode) &
               in_area;

endmodule // area_match

// [hw/lane_step.v]
// byte lane plan for one bus cycle of a sized operand
`timescale 1ns/100ps

module lane_step
(
  input  wire       addr_odd,
  input  wire       narrow,
  input  wire [2:0] left,
  output reg        use_lo,
  output reg        use_hi,
  output reg  [1:0] take
);

  // narrow bus: one byte on the low lane; wide bus: odd byte on the
  // upper lane, even pair on both lanes, lone even byte on the low lane
  always @*
  begin
    if (narrow)
    begin
      use_lo = 1'b1;
      use_hi = 1'b0;
      take   = 2'h1;
    end
    else if (addr_odd)
    begin
      use_lo = 1'b0;
      use_hi = 1'b1;
      take   = 2'h1;
    end
    else if (left >= 3'h2)
    begin
      use_lo = 1'b1;
      use_hi = 1'b1;
      take   = 2'h2;
    end
    else
    begin
      use_lo = 1'b1;
      use_hi = 1'b0;
      take   = 2'h1;
    end
  end

endmodule // lane_step

// [hw/chip_select_wait_controller.v]
// chip select, wait-state and bus sizing controller with APB registers
//
// The APB register port was decided locally.
`timescale 1ns/100ps
`include "csw_defs.vh"

module chip_select_wait_controller
#(
  parameter NO_INT_RAM = 0,
  parameter INT_ROM    = 0
)
(
  input  wire        pclk,
  input  wire        presetn,
  input  wire        clk_en,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // CPU mode, gates register writes and system-only blocks
  input  wire        system_mode,
  // CPU access request, held until acc_done
  input  wire        acc_req,
  input  wire        acc_write,
  input  wire [1:0]  acc_size,
  input  wire [23:0] acc_addr,
  input  wire [31:0] acc_wdata,
  output reg         acc_done,
  output reg  [31:0] acc_rdata,
  // external memory bus
  output reg  [23:0] mem_addr,
  output reg  [15:0] mem_dout,
  input  wire [15:0] mem_din,
  output reg         mem_oe_lo_n,
  output reg         mem_oe_hi_n,
  output reg         mem_rd_n,
  output reg         mem_wr_lo_n,
  output reg         mem_wr_hi_n,
  input  wire        mem_wait_n,
  output reg         block0_strobe_pin_n,
  output reg         block1_strobe_pin_n,
  output reg         block2_strobe_pin_n
);

  // bus cycle states
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_LOAD = 3'h1;
  localparam [2:0] S_T1   = 3'h2;
  localparam [2:0] S_TW   = 3'h3;
  localparam [2:0] S_T2   = 3'h4;

  localparam [23:0] B1_LO = NO_INT_RAM ? `CSW_B1_LO_NORAM : `CSW_B1_LO;
  localparam [23:0] B2_LO = INT_ROM ? `CSW_B2_LO_ROM : `CSW_B2_LO;

  reg  [7:0]  block0_select_wait_ctrl;
  reg  [7:0]  block1_select_wait_ctrl;
  reg  [7:0]  block2_select_wait_ctrl;
  reg  [2:0]  state_reg;
  reg  [23:0] addr_reg;
  reg  [2:0]  left_reg;
  reg  [1:0]  bi_reg;
  reg         write_reg;
  reg  [31:0] wdata_reg;
  reg  [1:0]  wcnt_reg;
  reg  [1:0]  mode_reg;
  reg  [1:0]  blk_reg;
  reg         cas_reg;
  reg         lo_reg;
  reg         hi_reg;
  reg  [1:0]  take_reg;

  wire        hit0;
  wire        hit1;
  wire        hit2;
  wire        use_lo;
  wire        use_hi;
  wire [1:0]  take;
  reg  [7:0]  cfg_sel;
  reg  [1:0]  blk_sel;
  reg         narrow;
  reg  [1:0]  ws;
  reg  [1:0]  hi_idx;

  wire apb_setup = psel & ~penable;
  // writes land at the access edge, where the master samples pready high
  wire reg_wr_ok = psel & penable & pready & pwrite & system_mode;

  // one matcher per block on the address of the current bus cycle
  area_match
  #(
    .FIXED_LO (`CSW_B0_LO),
    .FIXED_HI (`CSW_B0_HI)
  )
  u_match0
  (
    .cfg         (block0_select_wait_ctrl),
    .addr        (addr_reg),
    .system_mode (system_mode),
    .hit         (hit0)
  );

  area_match
  #(
    .FIXED_LO (B1_LO),
    .FIXED_HI (`CSW_B1_HI)
  )
  u_match1
  (
    .cfg         (block1_select_wait_ctrl),
    .addr        (addr_reg),
    .system_mode (system_mode),
    .hit         (hit1)
  );

  area_match
  #(
    .FIXED_LO (B2_LO),
    .FIXED_HI (`CSW_B2_HI)
  )
  u_match2
  (
    .cfg         (block2_select_wait_ctrl),
    .addr        (addr_reg),
    .system_mode (system_mode),
    .hit         (hit2)
  );

  // block zero wins an overlap, then one, then two
  always @*
  begin
    if (hit0)
    begin
      cfg_sel = block0_select_wait_ctrl;
      blk_sel = 2'h0;
    end
    else if (hit1)
    begin
      cfg_sel = block1_select_wait_ctrl;
      blk_sel = 2'h1;
    end
    else if (hit2)
    begin
      cfg_sel = block2_select_wait_ctrl;
      blk_sel = 2'h2;
    end
    else
    begin
      cfg_sel = 8'h00;
      blk_sel = 2'h3;
    end
  end

  // width and wait count of the cycle; unmatched space is wide, no wait
  always @*
  begin
    narrow = (blk_sel != 2'h3) & cfg_sel[`CSW_BIT_WIDTH];
    if (blk_sel == 2'h3)
      ws = `CSW_WS_NONE;
    else
    begin
      case (cfg_sel[`CSW_WAIT_HI:`CSW_WAIT_LO])
        `CSW_WAIT_TWO:  ws = `CSW_WS_TWO;
        `CSW_WAIT_ONE:  ws = `CSW_WS_ONE;
        `CSW_WAIT_PIN:  ws = `CSW_WS_ONE;
        `CSW_WAIT_NONE: ws = `CSW_WS_NONE;
        default:        ws = `CSW_WS_NONE;
      endcase
    end
  end

  // lane plan splits the operand into bus cycles
  lane_step u_step
  (
    .addr_odd (addr_reg[0]),
    .narrow   (narrow),
    .left     (left_reg),
    .use_lo   (use_lo),
    .use_hi   (use_hi),
    .take     (take)
  );

  // operand byte carried on the upper lane
  always @*
  begin
    if (use_lo)
      hi_idx = bi_reg + 2'h1;
    else
      hi_idx = bi_reg;
  end

  // APB slave: one access cycle, registers answer at the first one
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      block0_select_wait_ctrl <= `CSW_RST_BLK0;
      block1_select_wait_ctrl <= `CSW_RST_BLK1;
      block2_select_wait_ctrl <= `CSW_RST_BLK2;
      prdata                  <= 32'h00000000;
      pready                  <= 1'b0;
      pslverr                 <= 1'b0;
    end
    else if (clk_en)
    begin
      pready  <= apb_setup;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      if (apb_setup)
      begin
        case (paddr)
          `CSW_ADDR_BLK0:
          begin
            prdata <= {24'h000000, block0_select_wait_ctrl};
            pslverr <= pwrite & ~system_mode;
          end
          `CSW_ADDR_BLK1:
          begin
            prdata <= {24'h000000, block1_select_wait_ctrl};
            pslverr <= pwrite & ~system_mode;
          end
          `CSW_ADDR_BLK2:
          begin
            prdata <= {24'h000000, block2_select_wait_ctrl};
            pslverr <= pwrite & ~system_mode;
          end
          `CSW_ADDR_STAT:
          begin
            prdata  <= {24'h000000, blk_reg, cas_reg, 2'b00, state_reg};
            pslverr <= pwrite;
          end
          default:
            pslverr <= 1'b1;
        endcase
      end
      if (reg_wr_ok && (paddr == `CSW_ADDR_BLK0))
        block0_select_wait_ctrl <= pwdata[7:0];
      if (reg_wr_ok && (paddr == `CSW_ADDR_BLK1))
        block1_select_wait_ctrl <= pwdata[7:0];
      if (reg_wr_ok && (paddr == `CSW_ADDR_BLK2))
        block2_select_wait_ctrl <= pwdata[7:0];
    end
  end

  // bus cycle sequencer
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg           <= S_IDLE;
      addr_reg            <= 24'h000000;
      left_reg            <= 3'h0;
      bi_reg              <= 2'h0;
      write_reg           <= 1'b0;
      wdata_reg           <= 32'h00000000;
      wcnt_reg            <= 2'h0;
      mode_reg            <= 2'h0;
      blk_reg             <= 2'h3;
      cas_reg             <= 1'b0;
      lo_reg              <= 1'b0;
      hi_reg              <= 1'b0;
      take_reg            <= 2'h0;
      acc_done            <= 1'b0;
      acc_rdata           <= 32'h00000000;
      mem_addr            <= 24'h000000;
      mem_dout            <= 16'h0000;
      mem_oe_lo_n         <= 1'b1;
      mem_oe_hi_n         <= 1'b1;
      mem_rd_n            <= 1'b1;
      mem_wr_lo_n         <= 1'b1;
      mem_wr_hi_n         <= 1'b1;
      block0_strobe_pin_n <= 1'b1;
      block1_strobe_pin_n <= 1'b1;
      block2_strobe_pin_n <= 1'b1;
    end
    else if (clk_en)
    begin
      acc_done <= 1'b0;
      case (state_reg)
        // take a new operand
        S_IDLE:
        begin
          if (acc_req && !acc_done)
          begin
            addr_reg  <= acc_addr;
            write_reg <= acc_write;
            wdata_reg <= acc_wdata;
            bi_reg    <= 2'h0;
            acc_rdata <= 32'h00000000;
            case (acc_size)
              `CSW_OP_HALF: left_reg <= 3'h2;
              `CSW_OP_WORD: left_reg <= 3'h4;
              default:      left_reg <= 3'h1;
            endcase
            state_reg <= S_LOAD;
          end
        end
        // plan the next bus cycle and drive address, lanes, strobe
        S_LOAD:
        begin
          blk_reg     <= blk_sel;
          cas_reg     <= cfg_sel[`CSW_BIT_WAVE];
          mode_reg    <= cfg_sel[`CSW_WAIT_HI:`CSW_WAIT_LO];
          wcnt_reg    <= ws;
          lo_reg      <= use_lo;
          hi_reg      <= use_hi;
          take_reg    <= take;
          mem_addr    <= addr_reg;
          mem_dout    <= {wdata_reg[8*hi_idx +: 8], wdata_reg[8*bi_reg +: 8]};
          mem_oe_lo_n <= ~(write_reg & use_lo);
          mem_oe_hi_n <= ~(write_reg & use_hi);
          mem_rd_n    <= write_reg;
          // chip select falls with the address unless the waveform bit delays it to T1
          block0_strobe_pin_n <= ~((blk_sel == 2'h0) &
                                   ~cfg_sel[`CSW_BIT_WAVE]);
          block1_strobe_pin_n <= ~((blk_sel == 2'h1) &
                                   ~cfg_sel[`CSW_BIT_WAVE]);
          block2_strobe_pin_n <= ~((blk_sel == 2'h2) &
                                   ~cfg_sel[`CSW_BIT_WAVE]);
          state_reg   <= S_T1;
        end
        // second half: column strobe and write strobes fall
        S_T1:
        begin
          if (cas_reg)
          begin
            block0_strobe_pin_n <= ~(blk_reg == 2'h0);
            block1_strobe_pin_n <= ~(blk_reg == 2'h1);
            block2_strobe_pin_n <= ~(blk_reg == 2'h2);
          end
          mem_wr_lo_n <= ~(write_reg & lo_reg);
          mem_wr_hi_n <= ~(write_reg & hi_reg);
          if (wcnt_reg != `CSW_WS_NONE)
            state_reg <= S_TW;
          else
            state_reg <= S_T2;
        end
        // wait states; pin mode holds the last one while the pin is low
        S_TW:
        begin
          if (wcnt_reg > 2'h1)
            wcnt_reg <= wcnt_reg - 2'h1;
          else if (!((blk_reg != 2'h3) && (mode_reg == `CSW_WAIT_PIN) &&
                     !mem_wait_n))
            state_reg <= S_T2;
        end
        // end of cycle: capture used lanes, release, step the operand
        S_T2:
        begin
          if (!write_reg && lo_reg)
            acc_rdata[8*bi_reg +: 8] <= mem_din[7:0];
          if (!write_reg && hi_reg)
            acc_rdata[8*(lo_reg ? bi_reg + 2'h1 : bi_reg) +: 8]
              <= mem_din[15:8];
          mem_rd_n            <= 1'b1;
          mem_wr_lo_n         <= 1'b1;
          mem_wr_hi_n         <= 1'b1;
          mem_oe_lo_n         <= 1'b1;
          mem_oe_hi_n         <= 1'b1;
          block0_strobe_pin_n <= 1'b1;
          block1_strobe_pin_n <= 1'b1;
          block2_strobe_pin_n <= 1'b1;
          addr_reg  <= addr_reg + {22'h000000, take_reg};
          bi_reg    <= bi_reg + take_reg;
          left_reg  <= left_reg - {1'b0, take_reg};
          if (left_reg == {1'b0, take_reg})
          begin
            acc_done  <= 1'b1;
            state_reg <= S_IDLE;
          end
          else
            state_reg <= S_LOAD;
        end
        default:
          state_reg <= S_IDLE;
      endcase
    end
  end

endmodule // chip_select_wait_controller

// [verif/csw_checker.sv]
// port assertions for the chip select and wait-state controller
`timescale 1ns/100ps
`include "csw_defs.vh"
module csw_checker
(
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic        system_mode,
  input logic        pready,
  input logic        acc_done,
  input logic [23:0] mem_addr,
  input logic        mem_rd_n,
  input logic        mem_oe_lo_n,
  input logic        mem_wr_lo_n,
  input logic        mem_oe_hi_n,
  input logic        mem_wr_hi_n,
  input logic        block0_strobe_pin_n,
  input logic        block2_strobe_pin_n
);
  logic [7:0] cfg0;
  logic [7:0] cfg2;
  logic       hit0;
  logic       hit2;
  logic       rd_b2;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // shadow of blocks zero and two, taken at the access edge
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg0 <= `CSW_RST_BLK0;
      cfg2 <= `CSW_RST_BLK2;
    end
    else if (psel && penable && pready && pwrite && system_mode)
    begin
      if (paddr == `CSW_ADDR_BLK0)
        cfg0 <= pwdata[7:0];
      if (paddr == `CSW_ADDR_BLK2)
        cfg2 <= pwdata[7:0];
    end
  end
  // bus address inside the area each block is set to
  assign hit0 = cfg0[1:0] == 2'b00 ? mem_addr[23:8] == 16'h007F
                                    : mem_addr[23:22] == cfg0[1:0];
  assign hit2 = cfg2[1:0] == 2'b00 ?
                (mem_addr >= `CSW_B2_LO && mem_addr <= `CSW_B2_HI)
                : mem_addr[23:22] == cfg2[1:0];
  assign rd_b2 = !mem_rd_n && !block2_strobe_pin_n;
  property p_ready;
    psel && !penable |=> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("no ready after setup");
  property p_done;
    acc_done |=> !acc_done;
  endproperty
  a_done: assert property (p_done) else $error("done longer than a cycle");
  property p_blk0;
    !block0_strobe_pin_n |-> cfg0[7] && hit0 && (system_mode || !cfg0[6]);
  endproperty
  a_blk0: assert property (p_blk0) else $error("block zero strobe wrong");
  property p_blk2;
    !block2_strobe_pin_n |-> cfg2[7] && hit2;
  endproperty
  a_blk2: assert property (p_blk2) else $error("block two strobe wrong");
  property p_narrow;
    !block2_strobe_pin_n && cfg2[4] |-> mem_wr_hi_n && mem_oe_hi_n;
  endproperty
  a_narrow: assert property (p_narrow) else $error("upper lane in 8-bit");
  property p_lane;
    mem_oe_hi_n |-> mem_wr_hi_n;
  endproperty
  a_lane: assert property (p_lane) else $error("strobe on floating lane");
  property p_lane_lo;
    mem_oe_lo_n |-> mem_wr_lo_n;
  endproperty
  a_lane_lo: assert property (p_lane_lo) else $error("low strobe floating");
  property p_wait0;
    $rose(rd_b2) && cfg2[3:2] == 2'b00 |=> !mem_rd_n [*3] ##1 mem_rd_n;
  endproperty
  a_wait0: assert property (p_wait0) else $error("not two waits");
  property p_wait1;
    $rose(rd_b2) && cfg2[3:2] == 2'b01 |=> !mem_rd_n [*2] ##1 mem_rd_n;
  endproperty
  a_wait1: assert property (p_wait1) else $error("not one wait");
  property p_wait3;
    $rose(rd_b2) && cfg2[3:2] == 2'b11 |=> !mem_rd_n ##1 mem_rd_n;
  endproperty
  a_wait3: assert property (p_wait3) else $error("waits in 0-wait mode");
endmodule // csw_checker

// [verif/ext_mem_model.sv]
// external memory answering on the controller's memory bus
`timescale 1ns/100ps
module ext_mem_model
(
  input  logic        pclk,
  input  logic        narrow,
  input  int          hold,
  input  logic [23:0] mem_addr,
  input  logic [15:0] mem_dout,
  input  logic        mem_rd_n,
  input  logic        mem_wr_lo_n,
  input  logic        mem_wr_hi_n,
  output logic [15:0] mem_din,
  output logic        mem_wait_n
);
  logic [7:0] wmem [logic [23:0]];
  logic       act = 0;
  int         cnt = 0;
  wire        busy = !(mem_rd_n && mem_wr_lo_n && mem_wr_hi_n);
  // byte image of the memory
  function automatic logic [7:0] pat(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'hA5;
  endfunction
  // wait pin low for hold cycles from each bus cycle start
  assign mem_wait_n = cnt == 0;
  initial mem_din = 16'h0000;
  // unread lanes toggle so stale data never matches
  always @(posedge pclk)
  begin
    act <= busy;
    cnt <= busy && !act ? hold : (cnt > 0 ? cnt - 1 : 0);
    if (!mem_rd_n)
      mem_din <= narrow ? {~mem_din[15:8], pat(mem_addr)}
                        : {pat(mem_addr | 24'h1), pat(mem_addr & ~24'h1)};
    else
      mem_din <= ~mem_din;
    if (!mem_wr_lo_n)
      wmem[narrow ? mem_addr : mem_addr & ~24'h1] = mem_dout[7:0];
    if (!mem_wr_hi_n)
      wmem[mem_addr | 24'h1] = mem_dout[15:8];
  end
endmodule // ext_mem_model

// [verif/chip_select_wait_controller_tb.sv]
// self-checking bench for the chip select and wait-state controller
`timescale 1ns/100ps
`include "csw_defs.vh"
module chip_select_wait_controller_tb;
  logic        pclk = 0;
  logic        presetn = 0;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic        system_mode = 1;
  logic        acc_req = 0;
  logic        acc_write = 0;
  logic [1:0]  acc_size = 0;
  logic [23:0] acc_addr = 0;
  logic [31:0] acc_wdata = 0;
  logic        narrow = 0;
  wire  [31:0] prdata, acc_rdata;
  wire         pready, pslverr, acc_done, mem_rd_n, mem_wait_n;
  wire         mem_oe_lo_n, mem_oe_hi_n, mem_wr_lo_n, mem_wr_hi_n;
  wire  [23:0] mem_addr;
  wire  [15:0] mem_dout, mem_din;
  wire  [2:0]  strb_n;
  integer      seed = 32'hd816ad83;
  int          num_errors = 0, n_tests = 0, cycles = 0, hold = 0;
  int          lat, nbc;
  int          lt [4];
  logic [31:0] rq, q, d, r;
  logic [23:0] a;
  logic [7:0]  c0, c1;
  logic [2:0]  seen, ld, es, el;
  logic [1:0]  s;
  logic        re, sm;
  // block zero and one settings, mode, address, strobes seen, at load
  localparam logic [46:0] TBL [7] = '{
    {8'h8C, 8'h00, 1'b1, 24'h007F3A, 3'b001, 3'b001},
    {8'hAC, 8'h00, 1'b1, 24'h007FC1, 3'b001, 3'b000},
    {8'hCC, 8'h8C, 1'b0, 24'h007F00, 3'b010, 3'b010},
    {8'hCC, 8'h8C, 1'b1, 24'h007FFF, 3'b001, 3'b001},
    {8'h4C, 8'h8C, 1'b1, 24'h007F80, 3'b010, 3'b010},
    {8'h0C, 8'h8C, 1'b1, 24'h000480, 3'b010, 3'b010},
    {8'h0C, 8'h8C, 1'b1, 24'h00047F, 3'b000, 3'b000}};
  chip_select_wait_controller DUT
  (
    .pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .system_mode(system_mode), .acc_req(acc_req), .acc_write(acc_write),
    .acc_size(acc_size), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
    .acc_done(acc_done), .acc_rdata(acc_rdata), .mem_addr(mem_addr),
    .mem_dout(mem_dout), .mem_din(mem_din), .mem_oe_lo_n(mem_oe_lo_n),
    .mem_oe_hi_n(mem_oe_hi_n), .mem_rd_n(mem_rd_n),
    .mem_wr_lo_n(mem_wr_lo_n), .mem_wr_hi_n(mem_wr_hi_n),
    .mem_wait_n(mem_wait_n), .block0_strobe_pin_n(strb_n[0]),
    .block1_strobe_pin_n(strb_n[1]), .block2_strobe_pin_n(strb_n[2])
  );
  ext_mem_model mem
  (
    .pclk(pclk), .narrow(narrow), .hold(hold), .mem_addr(mem_addr),
    .mem_dout(mem_dout), .mem_rd_n(mem_rd_n), .mem_wr_lo_n(mem_wr_lo_n),
    .mem_wr_hi_n(mem_wr_hi_n), .mem_din(mem_din), .mem_wait_n(mem_wait_n)
  );
  initial
    forever #2.5 pclk = ~pclk;
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task test_done;
    $display("errors %0d of %0d checks", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // one APB transfer, held until ready is sampled high
  task apb(input logic w, input logic [11:0] ad, input logic [7:0] wd);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1;
    do
      @(posedge pclk);
    while (pready !== 1);
    rq = prdata;
    re = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // one operand; counts cycles, bus cycles and strobes seen
  task acc(input logic w, input logic [1:0] sz, input logic [23:0] ad,
           input logic [31:0] wd);
    logic pm, mk;
    @(posedge pclk);
    acc_req <= 1;
    acc_write <= w;
    acc_size <= sz;
    acc_addr <= ad;
    acc_wdata <= wd;
    {lat, nbc, seen, ld, pm} = 0;
    do
    begin
      @(posedge pclk);
      mk = !(mem_rd_n && mem_wr_lo_n && mem_wr_hi_n);
      if (mk && !pm && nbc == 0)
        ld = ~strb_n;
      nbc += int'(mk && !pm);
      pm = mk;
      seen |= ~strb_n;
      lat++;
    end
    while (acc_done !== 1);
    q = acc_rdata;
    acc_req <= 0;
  endtask
  // bus cycles needed for an operand
  function automatic int nb(int sz, logic [23:0] ad, bit nar);
    int l = 1 << sz;
    int n = 0;
    int t;
    while (l > 0)
    begin
      t = (nar || ad[0] || l == 1) ? 1 : 2;
      l -= t;
      ad += 24'(t);
      n++;
    end
    return n;
  endfunction
  // operand expected from the memory image
  function automatic logic [31:0] ev(int sz, logic [23:0] ad);
    logic [31:0] v = 0;
    for (int k = 0; k < (1 << sz); k++)
      v[8*k +: 8] = mem.pat(ad + 24'(k));
    return v;
  endfunction
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      test_done;
    end
  end
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1;
    apb(0, `CSW_ADDR_BLK0, 0);
    chk(rq, 0);
    apb(0, `CSW_ADDR_BLK2, 0);
    chk(rq, 32'h80);
    apb(0, 12'h1B0, 0);
    chk(re, 1);
    // corner then random operands through block two
    for (int i = 0; i < 24; i++)
    begin
      r = $random(seed);
      if (i < 4)
        r = {i[1], 1'b0, 2'b10, 8'h00, 20'(i[0])};
      s = r[29:28] % 2'd3;
      a = 24'h8000 + 24'(r[19:0]);
      d = $random(seed);
      narrow <= r[30];
      apb(1, `CSW_ADDR_BLK2, {3'b100, r[30], 4'b1100});
      acc(r[31], s, a, d);
      chk(nbc, nb(s, a, r[30]));
      chk(seen, 3'b100);
      for (int k = 0; k < (1 << s) && r[31]; k++)
        chk(mem.wmem[a + 24'(k)], d[8*k +: 8]);
      if (!r[31])
        chk(q & (32'hFFFFFFFF >> (32 - (8 << s))), ev(s, a));
    end
    // wait modes with the wait pin held low, then released
    narrow <= 0;
    hold = 6;
    for (int wm = 0; wm < 4; wm++)
    begin
      apb(1, `CSW_ADDR_BLK2, 8'(8'h80 | wm << 2));
      acc(0, 2, 24'h8000, 0);
      lt[wm] = lat;
    end
    hold = 0;
    apb(1, `CSW_ADDR_BLK2, 8'h88);
    acc(0, 2, 24'h8000, 0);
    chk(lt[0] - lt[3], 4);
    chk(lt[1] - lt[3], 2);
    chk(lat - lt[3], 2);
    chk(lt[2] > lat, 1);
    // block zero in each upper area
    for (int ar = 1; ar < 4; ar++)
    begin
      r = $random(seed);
      apb(1, `CSW_ADDR_BLK0, 8'(8'h8C | ar));
      acc(0, 0, {2'(ar), r[21:0]}, 0);
      chk(seen, 3'b001);
    end
    // default areas, enable, system-only and waveform table
    for (int i = 0; i < 7; i++)
    begin
      {c0, c1, sm, a, es, el} = TBL[i];
      apb(1, `CSW_ADDR_BLK0, c0);
      apb(1, `CSW_ADDR_BLK1, c1);
      system_mode <= sm;
      acc(0, 0, a, 0);
      system_mode <= 1;
      chk(seen, es);
      chk(ld, el);
    end
    test_done;
  end
endmodule // chip_select_wait_controller_tb
bind chip_select_wait_controller csw_checker u_chk
(
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .system_mode(system_mode), .pready(pready), .acc_done(acc_done),
  .mem_addr(mem_addr), .mem_rd_n(mem_rd_n), .mem_oe_lo_n(mem_oe_lo_n),
  .mem_wr_lo_n(mem_wr_lo_n), .mem_oe_hi_n(mem_oe_hi_n),
  .mem_wr_hi_n(mem_wr_hi_n), .block0_strobe_pin_n(block0_strobe_pin_n),
  .block2_strobe_pin_n(block2_strobe_pin_n)
);
